// [flash_protect_pkg.sv]
// package for the flash block-protect decoder
// assumes a 16-bit flash address space with flash ending at the top address
`default_nettype none
package flash_protect_pkg;

	// ----------------------------------------
	// address composition
	// ----------------------------------------
	localparam int          ADDR_W          = 16;
	localparam int          FIELD_W         = 8;
	localparam int          FIELD_LSB       = 6;
	localparam logic [1:0]  ADDR_TOP_BITS   = 2'h3;
	localparam logic [5:0]  ADDR_LOW_BITS   = 6'h00;
	localparam logic [15:0] FLASH_TOP_ADDR  = 16'hffff;
	localparam logic [7:0]  FIELD_ALL_MAX   = 8'hb8;
	localparam logic [7:0]  FIELD_NONE      = 8'hff;

	// ----------------------------------------
	// apb register map
	// ----------------------------------------
	localparam logic [7:0]  REG_START_OFF   = 8'h00;
	localparam logic [7:0]  REG_STATUS_OFF  = 8'h04;
	localparam logic [7:0]  REG_BASE_OFF    = 8'h08;
	localparam logic [7:0]  PROTECT_RESET   = 8'hff;
	localparam int          ST_HIT_BIT      = 0;
	localparam int          ST_ALL_BIT      = 1;
	localparam int          ST_NONE_BIT     = 2;

	// ----------------------------------------
	// program / erase request bundle
	// ----------------------------------------
	typedef struct packed {
		logic        valid;
		logic        erase;
		logic [15:0] addr;
	} nvm_req_t;

endpackage
`default_nettype wire

// [flash_block_protect_decode.sv]
// flash block-protect decoder with apb read-back
// assumes the flash controller presents each program/erase request for one cycle
// and loads the protect byte from the array through a load strobe
// verdicts come one cycle after the request, so the caller must wait for them
`timescale 1ns/10ps
`default_nettype none

// Function
// - start address = 11, field, 000000
// - start address to top is protected
// - field 00..B8 protects whole array
// - field FF disables all protection
// - field FE gives start FF80
// - bus writes never change protect byte
module flash_block_protect_decode (
	// clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         rst,
	// protect byte load from the flash array
	input  wire logic                         nvm_load,
	input  wire logic [7:0]                   nvm_byte,
	// program / erase requests
	input  wire flash_protect_pkg::nvm_req_t  op_req,
	output var  logic                         op_grant,
	output var  logic                         op_blocked,
	output var  logic                         protect_hit,
	// apb slave
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [7:0]                   paddr,
	input  wire logic [31:0]                  pwdata,
	output var  logic [31:0]                  prdata,
	output var  logic                         pready,
	output var  logic                         pslverr
);

	// ----------------------------------------
	// protect byte storage
	// ----------------------------------------
	logic [7:0]  flash_protect_start_reg;
	logic [7:0]  flash_protect_start_next;

	// only the array load path may change it; apb writes are ignored
	assign flash_protect_start_next = nvm_load ? nvm_byte : flash_protect_start_reg;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flash_protect_start_reg <= flash_protect_pkg::PROTECT_RESET;
		end else begin
			flash_protect_start_reg <= flash_protect_start_next;
		end
	end

	// ----------------------------------------
	// protect byte checks
	// ----------------------------------------
	chk_load_take: assert property (@(posedge core_clk) disable iff (rst)
		nvm_load |=> flash_protect_start_reg == $past(nvm_byte))
		else $error("protect byte did not take the array value");

	// ----------------------------------------
	// start address decode
	// ----------------------------------------
	wire logic [15:0] start_addr;
	wire logic        protect_all;
	wire logic        protect_none;
	wire logic        addr_hit;

	assign start_addr   = {flash_protect_pkg::ADDR_TOP_BITS, flash_protect_start_reg,
	                       flash_protect_pkg::ADDR_LOW_BITS};
	assign protect_all  = flash_protect_start_reg <= flash_protect_pkg::FIELD_ALL_MAX;
	assign protect_none = flash_protect_start_reg == flash_protect_pkg::FIELD_NONE;
	// top of flash is the top of the space, so an upper bound test is always true
	assign addr_hit     = !protect_none && (protect_all || (op_req.addr >= start_addr
	                      && op_req.addr <= flash_protect_pkg::FLASH_TOP_ADDR));

	// ----------------------------------------
	// decode checks
	// ----------------------------------------
	chk_top_covered: assert property (@(posedge core_clk) disable iff (rst)
		op_req.valid && op_req.addr == flash_protect_pkg::FLASH_TOP_ADDR && !protect_none |=> op_blocked)
		else $error("top address of flash left open");

	// ----------------------------------------
	// request verdict, registered
	// ----------------------------------------
	logic grant_reg;
	logic blocked_reg;
	logic hit_reg;

	wire logic grant_next;
	wire logic blocked_next;
	wire logic hit_next;

	assign grant_next   = op_req.valid && !addr_hit;
	assign blocked_next = op_req.valid && addr_hit;
	// the last verdict stands until the next request, so software can read it later
	assign hit_next     = op_req.valid ? addr_hit : hit_reg;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			grant_reg <= 1'b0;
		end else begin
			grant_reg <= grant_next;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			blocked_reg <= 1'b0;
		end else begin
			blocked_reg <= blocked_next;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hit_reg <= 1'b0;
		end else begin
			hit_reg <= hit_next;
		end
	end

	assign op_grant    = grant_reg;
	assign op_blocked  = blocked_reg;
	assign protect_hit = hit_reg;

	// ----------------------------------------
	// request verdict checks
	// ----------------------------------------
	chk_grant_excl: assert property (@(posedge core_clk) disable iff (rst)
		!(op_grant && op_blocked))
		else $error("grant and block raised together");

	chk_one_verdict: assert property (@(posedge core_clk) disable iff (rst)
		op_req.valid |=> op_grant || op_blocked)
		else $error("request got no verdict");

	chk_no_spurious: assert property (@(posedge core_clk) disable iff (rst)
		!op_req.valid |=> !op_grant && !op_blocked)
		else $error("verdict without a request");

	chk_hit_hold: assert property (@(posedge core_clk) disable iff (rst)
		!op_req.valid |=> $stable(protect_hit))
		else $error("protect indication moved without a request");

	chk_hit_follows: assert property (@(posedge core_clk) disable iff (rst)
		op_req.valid |=> protect_hit == op_blocked)
		else $error("protect indication disagrees with block");

	chk_hit_none: assert property (@(posedge core_clk) disable iff (rst)
		op_req.valid && flash_protect_start_reg == flash_protect_pkg::FIELD_NONE |=> !protect_hit)
		else $error("erased field raised the protect indication");

	chk_hit_all: assert property (@(posedge core_clk) disable iff (rst)
		op_req.valid && flash_protect_start_reg <= flash_protect_pkg::FIELD_ALL_MAX |=> protect_hit)
		else $error("low field left an address unprotected");

	chk_vector_area: assert property (@(posedge core_clk) disable iff (rst)
		op_req.valid && flash_protect_start_reg == 8'hfe && op_req.addr >= 16'hff80 |=> op_blocked)
		else $error("vector area open with field fe");

	chk_vector_below: assert property (@(posedge core_clk) disable iff (rst)
		op_req.valid && flash_protect_start_reg == 8'hfe && op_req.addr < 16'hff80 |=> op_grant)
		else $error("area below ff80 blocked with field fe");

	// ----------------------------------------
	// apb slave: one wait-free access, read only
	// ----------------------------------------
	wire logic        apb_access;
	wire logic        sel_start;
	wire logic        sel_status;
	wire logic        sel_base;
	wire logic        addr_ok;
	wire logic [31:0] rd_mux;
	wire logic [31:0] rd_start;
	wire logic [31:0] rd_status;
	wire logic [31:0] rd_base;
	wire logic        rd_take;
	wire logic [31:0] prdata_next;
	wire logic        pready_next;
	wire logic        pslverr_next;
	logic [31:0]      prdata_reg;
	logic             pready_reg;
	logic             pslverr_reg;

	assign apb_access = psel && !penable;
	assign sel_start  = paddr == flash_protect_pkg::REG_START_OFF;
	assign sel_status = paddr == flash_protect_pkg::REG_STATUS_OFF;
	assign sel_base   = paddr == flash_protect_pkg::REG_BASE_OFF;
	assign addr_ok    = sel_start || sel_status || sel_base;
	assign rd_start   = {24'h00_0000, flash_protect_start_reg};
	assign rd_status  = {29'h0000_0000, protect_none, protect_all, hit_reg};
	assign rd_base    = {16'h0000, start_addr};
	assign rd_mux     = sel_start  ? rd_start :
	                    sel_status ? rd_status :
	                    sel_base   ? rd_base : 32'h0000_0000;
	assign rd_take    = apb_access && !pwrite;
	assign prdata_next  = rd_take ? rd_mux : 32'h0000_0000;
	assign pready_next  = apb_access;
	// writes are refused with an error and never touch the protect byte
	assign pslverr_next = apb_access && (pwrite || !addr_ok);

	// answer registered in setup so pready is high in the first access cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prdata_reg <= 32'h0000_0000;
		end else begin
			prdata_reg <= prdata_next;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= pready_next;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pslverr_reg <= 1'b0;
		end else begin
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;

	// ----------------------------------------
	// apb checks
	// ----------------------------------------
	chk_apb_pulse: assert property (@(posedge core_clk) disable iff (rst)
		pready |=> !pready)
		else $error("pready stood longer than one cycle");

	chk_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
		!pready |-> prdata == 32'h0000_0000)
		else $error("read data driven outside an answer");

	chk_err_ready: assert property (@(posedge core_clk) disable iff (rst)
		pslverr |-> pready)
		else $error("error raised without pready");

	chk_write_refused: assert property (@(posedge core_clk) disable iff (rst)
		psel && !penable && pwrite |=> pslverr && prdata == 32'h0000_0000)
		else $error("apb write not refused");

	chk_read_start: assert property (@(posedge core_clk) disable iff (rst)
		psel && !penable && !pwrite && paddr == flash_protect_pkg::REG_START_OFF
		|=> prdata == {24'h00_0000, $past(flash_protect_start_reg)})
		else $error("protect byte read back wrongly");

	chk_status_read: assert property (@(posedge core_clk) disable iff (rst)
		psel && !penable && !pwrite && paddr == flash_protect_pkg::REG_STATUS_OFF
		|=> prdata == {29'h0000_0000, $past(protect_none), $past(protect_all), $past(hit_reg)})
		else $error("status read back wrongly");

	chk_base_read: assert property (@(posedge core_clk) disable iff (rst)
		psel && !penable && !pwrite && paddr == flash_protect_pkg::REG_BASE_OFF
		|=> prdata == {16'h0000, $past(start_addr)})
		else $error("start address read back wrongly");

	chk_unmapped_err: assert property (@(posedge core_clk) disable iff (rst)
		psel && !penable && !addr_ok |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");

	chk_read_ok: assert property (@(posedge core_clk) disable iff (rst)
		psel && !penable && !pwrite && addr_ok |=> pready && !pslverr)
		else $error("mapped read answered with an error");

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_start_compose: assert property (@(posedge core_clk) disable iff (rst)
		start_addr[15:14] == 2'h3 && start_addr[5:0] == 6'h00 && start_addr[13:6] == flash_protect_start_reg)
		else $error("start address composed wrongly");
	chk_range_block: assert property (@(posedge core_clk) disable iff (rst)
		op_req.valid && flash_protect_start_reg > 8'hb8 && flash_protect_start_reg != 8'hff
		&& op_req.addr >= start_addr |=> op_blocked && !op_grant)
		else $error("address in protected range not blocked");
	chk_all_protect: assert property (@(posedge core_clk) disable iff (rst)
		op_req.valid && flash_protect_start_reg <= 8'hb8 |=> op_blocked)
		else $error("low field did not protect whole array");
	chk_none_protect: assert property (@(posedge core_clk) disable iff (rst)
		op_req.valid && flash_protect_start_reg == 8'hff |=> op_grant && !op_blocked)
		else $error("erased field still protects");
	chk_fe_start: assert property (@(posedge core_clk) disable iff (rst)
		flash_protect_start_reg == 8'hfe |-> start_addr == 16'hff80)
		else $error("field fe did not start at ff80");
	chk_bus_nowrite: assert property (@(posedge core_clk) disable iff (rst)
		!nvm_load |=> $stable(flash_protect_start_reg))
		else $error("protect byte changed without array load");
	chk_below_grant: assert property (@(posedge core_clk) disable iff (rst)
		op_req.valid && flash_protect_start_reg > 8'hb8 && op_req.addr < start_addr |=> op_grant)
		else $error("unprotected address was blocked");
	chk_verdict_excl: assert property (@(posedge core_clk) disable iff (rst)
		op_blocked |-> !op_grant && protect_hit && $past(op_req.valid))
		else $error("blocked without a request or with grant");
	chk_apb_ready: assert property (@(posedge core_clk) disable iff (rst)
		psel && !penable |=> pready)
		else $error("apb access not answered in first access cycle");

endmodule

`default_nettype wire

// [flash_cpu_model.sv]
// cpu model: erase requests (erase bit always set) and protect byte loads
// assumes the decoder samples on core_clk rising edges
`timescale 1ns/10ps
`default_nettype none
module flash_cpu_model (
	// clock
	input  wire logic                        core_clk,
	// toward the decoder
	output var  flash_protect_pkg::nvm_req_t op_req,
	output var  logic                        nvm_load,
	output var  logic [7:0]                  nvm_byte
);
	// ----------------------------------------
	// sequences
	// ----------------------------------------
	initial begin
		op_req = '0;
		nvm_load = 1'b0;
		nvm_byte = 8'h5a;
	end
	// idle lines show the inverse, never a stale value
	task automatic load_byte(input logic [7:0] b);
		@(posedge core_clk);
		nvm_load <= 1'b1;
		nvm_byte <= b;
		@(posedge core_clk);
		nvm_load <= 1'b0;
		nvm_byte <= ~b;
	endtask
	task automatic request(input logic [15:0] a);
		@(posedge core_clk);
		op_req <= {1'b1, 1'b1, a};
		@(posedge core_clk);
		op_req <= {1'b0, 1'b0, ~a};
	endtask
endmodule
`default_nettype wire

// [tb.sv]
// testbench for the flash block-protect decoder
// assumes apb answers within a few cycles and verdicts one cycle after a request
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic                        core_clk, rst, psel, penable, pwrite, err;
	logic                        nvm_load, op_grant, op_blocked, protect_hit, pready, pslverr;
	logic [7:0]                  paddr, nvm_byte;
	logic [31:0]                 pwdata, prdata, rd;
	logic [15:0]                 st;
	flash_protect_pkg::nvm_req_t op_req;
	int                          mismatches, n_tests, cyc;
	logic [7:0]                  fv [6] = '{8'h00, 8'hb8, 8'hb9, 8'hdf, 8'hfe, 8'hff};
	flash_block_protect_decode dut (.core_clk(core_clk), .rst(rst), .nvm_load(nvm_load),
		.nvm_byte(nvm_byte), .op_req(op_req), .op_grant(op_grant), .op_blocked(op_blocked),
		.protect_hit(protect_hit), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	flash_cpu_model cpu (.core_clk(core_clk), .op_req(op_req), .nvm_load(nvm_load), .nvm_byte(nvm_byte));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	function automatic logic hit(input logic [7:0] f, input logic [15:0] a);
		if (f == flash_protect_pkg::FIELD_NONE) return 1'b0;
		if (f <= flash_protect_pkg::FIELD_ALL_MAX) return 1'b1;
		return a >= {2'h3, f, 6'h00};
	endfunction
	task automatic op(input logic [7:0] f, input logic [15:0] a);
		cpu.request(a);
		@(posedge core_clk);
		chk("blocked", {31'h0, hit(f, a)}, {31'h0, op_blocked});
		chk("grant", {31'h0, !hit(f, a)}, {31'h0, op_grant});
	endtask
	task automatic wrap_up;
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------
	// clock, timeout and sequence
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		apb(1'b0, 8'h00, 32'h0);
		chk("reset byte", 32'h0000_00ff, rd);
		foreach (fv[i]) begin
			cpu.load_byte(fv[i]);
			st = {2'h3, fv[i], 6'h00};
			apb(1'b0, 8'h08, 32'h0);
			chk("start", {16'h0, st}, rd);
			chk("read err", 32'h0, {31'h0, err});
			op(fv[i], st - 16'h0001);
			op(fv[i], st);
			op(fv[i], 16'hffff);
			op(fv[i], 16'h0000);
			chk("hit", {31'h0, hit(fv[i], 16'h0000)}, {31'h0, protect_hit});
			apb(1'b0, 8'h04, 32'h0);
			chk("status", {29'h0, fv[i] == 8'hff, fv[i] <= 8'hb8, hit(fv[i], 16'h0000)}, rd);
		end
		apb(1'b1, 8'h00, 32'h0000_0012);
		chk("write err", 32'h1, {31'h0, err});
		apb(1'b0, 8'h00, 32'h0);
		chk("byte kept", 32'h0000_00ff, rd);
		apb(1'b0, 8'h0c, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		wrap_up();
	end
endmodule
`default_nettype wire
